//--- hw/dbsc_pkg.sv
// constants shared by the display buffer and scroll configuration block
package dbsc_pkg;
  // register port offsets
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_COMMAND = 4'h1;
  localparam logic [3:0] ADDR_CURSOR_LOW = 4'h2;
  localparam logic [3:0] ADDR_CURSOR_HIGH = 4'h3;
  localparam logic [3:0] ADDR_DATA = 4'h4;
  localparam logic [3:0] ADDR_VCU_CFG = 4'h7;
  localparam logic [3:0] ADDR_FIRST_LOW = 4'h8;
  localparam logic [3:0] ADDR_BOUNDS_HIGH = 4'h9;
  localparam logic [3:0] ADDR_PTR_LOW = 4'ha;
  localparam logic [3:0] ADDR_PTR_HIGH = 4'hb;
  localparam logic [3:0] ADDR_SPLIT_ONE = 4'hc;
  localparam logic [3:0] ADDR_SPLIT_TWO = 4'hd;
  localparam logic [3:0] ADDR_DOUBLE_LINES = 4'he;
  // status bit positions
  localparam int STAT_SPLIT1_BIT = 0;
  localparam int STAT_SPLIT2_BIT = 1;
  localparam int STAT_READY_BIT = 5;
  // field positions
  localparam int CFG_BLINK_EN_BIT = 5;
  localparam int CFG_BLINK_RATE_BIT = 4;
  localparam int PTRH_ZERO_LINES_SCROLL_DOWN_BIT = 7;
  localparam int PTRH_ZERO_LINES_SCROLL_UP_BIT = 6;
  localparam int SPLIT_SCROLL_BIT = 7;
  // pointer access commands
  localparam logic [7:0] CMD_READ_PTR = 8'h01;
  localparam logic [7:0] CMD_WRITE_PTR = 8'h02;
  localparam logic [7:0] CMD_FILL_TO_PTR = 8'h03;
  // buffer geometry: last address is the top nibble over ten set bits
  localparam logic [9:0] LAST_LOW_ONES = 10'h3ff;
  // blink divider taps: frame counter bit 4 gives 1/32, bit 5 gives 1/64
  localparam int BLINK_FAST_TAP = 4;
  localparam int BLINK_SLOW_TAP = 5;
  // double size codes
  localparam logic [1:0] DS_NORMAL = 2'h0;
  localparam logic [1:0] DS_WIDE = 2'h1;
  localparam logic [1:0] DS_WIDE_TOPS = 2'h2;
  localparam logic [1:0] DS_WIDE_BOTS = 2'h3;
  // reset value of every configuration register
  localparam logic [7:0] REG_RESET = 8'h00;
  // clock period and read data latency in cycles
  localparam int CLK_PERIOD_NS = 40;
  localparam int READ_LATENCY_CYC = 1;
  // pointer access sequencer states
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_READ = 5'b00010,
    ST_CAPTURE = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_FILL = 5'b10000
  } dbsc_state_type;
endpackage

//--- hw/dbsc_blink.sv
// cursor blink divider counting vertical sync pulses
`timescale 1ns/1ps
`default_nettype none
module dbsc_blink (
  // clocking
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // frame events and settings
  input wire logic vsync_pulse,
  input wire logic blink_en,
  input wire logic rate_slow,
  // blink phase, high while the cursor shows
  output logic blink_q
);
  import dbsc_pkg::*;
  logic [5:0] frame_cnt_q; // free running frame counter
  logic [5:0] frame_cnt_d;
  logic blink_d;
  assign frame_cnt_d = vsync_pulse ? frame_cnt_q + 6'h01 : frame_cnt_q;
  // a disabled blink keeps the cursor steadily on
  assign blink_d = !blink_en ? 1'b1 :
                   rate_slow ? !frame_cnt_q[BLINK_SLOW_TAP] : !frame_cnt_q[BLINK_FAST_TAP];
  // counter and phase register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      frame_cnt_q <= 6'h00;
      blink_q <= 1'b1;
    end else if (ce) begin
      frame_cnt_q <= frame_cnt_d;
      blink_q <= blink_d;
    end
  end
endmodule
`default_nettype wire

//--- hw/dbsc_wrap.sv
// display address counter with buffer wraparound
`timescale 1ns/1ps
`default_nettype none
module dbsc_wrap (
  // clocking
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // raster events
  input wire logic frame_start,
  input wire logic char_adv,
  input wire logic row_end,
  input wire logic screen_end,
  input wire logic start_reloaded,
  input wire logic split_load,
  // addresses
  input wire logic [13:0] screen_start,
  input wire logic [13:0] split_addr,
  input wire logic [11:0] first_addr,
  input wire logic [3:0] last_nib,
  // current display address
  output logic [13:0] disp_addr_q
);
  import dbsc_pkg::*;
  logic [13:0] last_addr;
  logic at_last;
  logic to_start;
  logic [13:0] disp_addr_d;
  assign last_addr = {last_nib, LAST_LOW_ONES};
  assign at_last = disp_addr_q == last_addr;
  // start address wins over wrap at a reloaded row end or at screen end
  assign to_start = (row_end && start_reloaded) || screen_end;
  assign disp_addr_d = frame_start ? screen_start :
                       split_load ? split_addr :
                       !char_adv ? disp_addr_q :
                       !at_last ? disp_addr_q + 14'h0001 :
                       to_start ? screen_start : {2'h0, first_addr};
  // address register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      disp_addr_q <= 14'h0000;
    end else if (ce) begin
      disp_addr_q <= disp_addr_d;
    end
  end
endmodule
`default_nettype wire

//--- hw/dbsc_top.sv
// display buffer bounds, pointer access, blink, underline and scroll config
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dbsc_top (
  // clocking
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // buffer memory port for pointer accesses
  output logic [13:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  input wire logic [7:0] mem_rdata,
  // raster timing inputs
  input wire logic blank,
  input wire logic vsync_pulse,
  input wire logic frame_start,
  input wire logic char_adv,
  input wire logic row_end,
  input wire logic screen_end,
  input wire logic start_reloaded,
  input wire logic first_line,
  input wire logic [6:0] row_index,
  input wire logic [3:0] line_count,
  input wire logic partial_row,
  input wire logic scroll_down,
  input wire logic split_load,
  input wire logic [13:0] screen_start,
  input wire logic [13:0] split_addr,
  // display outputs
  output logic [13:0] disp_addr,
  output logic address_underline_shared_pin,
  output logic address_double_width_shared_pin,
  output logic [3:0] line_address,
  output logic [3:0] scroll_offset,
  output logic [1:0] row_double,
  output logic cursor_blink
);
  import dbsc_pkg::*;

  // configuration registers
  logic [7:0] vsync_cursor_underline_cfg_q;
  logic [7:0] buffer_first_address_low_q;
  logic [7:0] buffer_bounds_high_q;
  logic [7:0] pointer_address_low_q;
  logic [7:0] pointer_high_and_scroll_zero_q;
  logic [7:0] split_row_one_scroll_start_q;
  logic [7:0] split_row_two_scroll_end_q;
  logic [7:0] double_size_and_scroll_lines_q;
  logic [13:0] cursor_q; // start of the fill command
  logic [7:0] data_q; // write data and captured read data
  logic [1:0] split_stat_q; // sticky split status bits
  dbsc_state_type state_q;
  dbsc_state_type state_d;
  logic blank_q; // previous blank sample for edge detect
  logic ul_phase_q; // pins carry timing signals, not address
  logic [1:0] dw_cond_q; // double size code of current row
  logic [13:0] disp_addr_q;

  // output registers
  logic [7:0] reg_rdata_q;
  logic [13:0] mem_addr_q;
  logic mem_we_q;
  logic mem_re_q;
  logic ul_pin_q;
  logic dw_pin_q;
  logic [3:0] line_address_q;
  logic [3:0] scroll_offset_q;
  logic blink_q;

  // decode helper used for every register select
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = a == off;
  endfunction

  // field extraction
  wire [13:0] pointer = {pointer_high_and_scroll_zero_q[5:0], pointer_address_low_q};
  wire [11:0] first_addr = {buffer_bounds_high_q[3:0], buffer_first_address_low_q};
  wire [3:0] last_nib = buffer_bounds_high_q[7:4];
  wire zero_lines_scroll_down = pointer_high_and_scroll_zero_q[PTRH_ZERO_LINES_SCROLL_DOWN_BIT];
  wire zero_lines_scroll_up = pointer_high_and_scroll_zero_q[PTRH_ZERO_LINES_SCROLL_UP_BIT];
  wire scroll_start = split_row_one_scroll_start_q[SPLIT_SCROLL_BIT];
  wire scroll_end = split_row_two_scroll_end_q[SPLIT_SCROLL_BIT];
  wire [6:0] split_one = split_row_one_scroll_start_q[6:0];
  wire [6:0] split_two = split_row_two_scroll_end_q[6:0];
  wire [1:0] double_one = double_size_and_scroll_lines_q[7:6];
  wire [1:0] double_two = double_size_and_scroll_lines_q[5:4];
  wire [3:0] lines_to_scroll_field = double_size_and_scroll_lines_q[3:0];
  wire [3:0] underline_line = vsync_cursor_underline_cfg_q[3:0];

  // register port decode
  wire is_idle = state_q == ST_IDLE;
  wire pointer_ready_flag = is_idle;
  wire wr_status = reg_wr && hit(reg_addr, ADDR_STATUS);
  wire wr_command = reg_wr && hit(reg_addr, ADDR_COMMAND);
  wire cmd_read = wr_command && is_idle && reg_wdata == CMD_READ_PTR;
  wire cmd_write = wr_command && is_idle && reg_wdata == CMD_WRITE_PTR;
  wire cmd_fill = wr_command && is_idle && reg_wdata == CMD_FILL_TO_PTR;
  // pointer writes while busy are refused so a running command keeps its target
  wire ptr_lock = !is_idle;
  wire [7:0] status_word = {2'h0, pointer_ready_flag, 3'h0, split_stat_q};

  // read data selection, unmapped offsets read zero
  wire [7:0] rd_mux =
    hit(reg_addr, ADDR_STATUS) ? status_word :
    hit(reg_addr, ADDR_CURSOR_LOW) ? cursor_q[7:0] :
    hit(reg_addr, ADDR_CURSOR_HIGH) ? {2'h0, cursor_q[13:8]} :
    hit(reg_addr, ADDR_DATA) ? data_q :
    hit(reg_addr, ADDR_VCU_CFG) ? vsync_cursor_underline_cfg_q :
    hit(reg_addr, ADDR_FIRST_LOW) ? buffer_first_address_low_q :
    hit(reg_addr, ADDR_BOUNDS_HIGH) ? buffer_bounds_high_q :
    hit(reg_addr, ADDR_PTR_LOW) ? pointer_address_low_q :
    hit(reg_addr, ADDR_PTR_HIGH) ? pointer_high_and_scroll_zero_q :
    hit(reg_addr, ADDR_SPLIT_ONE) ? split_row_one_scroll_start_q :
    hit(reg_addr, ADDR_SPLIT_TWO) ? split_row_two_scroll_end_q :
    hit(reg_addr, ADDR_DOUBLE_LINES) ? double_size_and_scroll_lines_q : 8'h00;

  // split row match at line zero; field n compares with zero-based row n
  wire split1_hit = first_line && row_index == split_one;
  wire split2_hit = first_line && row_index == split_two;
  // set wins over a write-one clear in the same cycle
  wire [1:0] split_stat_d = (split_stat_q & ~(wr_status ? reg_wdata[1:0] : 2'h0))
                            | {split2_hit, split1_hit};

  // blank edges steer the shared pins
  wire blank_fall = blank_q && !blank;
  wire blank_rise = !blank_q && blank;
  wire ul_phase_d = blank_fall ? 1'b1 : blank_rise ? 1'b0 : ul_phase_q;
  wire ul_hit = line_count == underline_line;
  wire ul_pin_d = ul_phase_d ? ul_hit : disp_addr_q[10];
  // every non-normal code is one of the double width variants
  wire [1:0] dw_cond_d = split1_hit ? double_one : split2_hit ? double_two : dw_cond_q;
  wire dw_wide = dw_cond_d != DS_NORMAL;
  wire dw_pin_d = ul_phase_d ? dw_wide : disp_addr_q[9];

  // partial row forcing: down and up both force line address zero
  wire force_down = partial_row && scroll_down && zero_lines_scroll_down;
  wire force_up = partial_row && !scroll_down && zero_lines_scroll_up;
  wire [3:0] line_address_d = (force_down || force_up) ? 4'h0 : line_count;
  wire scroll_on = scroll_start && scroll_end;
  wire [3:0] scroll_offset_d = scroll_on ? lines_to_scroll_field : 4'h0;

  // pointer access sequencer next state
  wire fill_done = mem_addr_q == pointer;
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_read) begin
          state_d = ST_READ;
        end else if (cmd_write) begin
          state_d = ST_WRITE;
        end else if (cmd_fill) begin
          state_d = ST_FILL;
        end
      end
      ST_READ: state_d = ST_CAPTURE; // memory answers one cycle after the strobe
      ST_CAPTURE: state_d = ST_IDLE;
      ST_WRITE: state_d = ST_IDLE;
      ST_FILL: begin
        if (fill_done) begin
          state_d = ST_IDLE; // pointer is the last location written
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // memory port values for the next cycle
  wire [13:0] mem_addr_d =
    (cmd_read || cmd_write) ? pointer :
    cmd_fill ? cursor_q :
    (state_q == ST_FILL && !fill_done) ? mem_addr_q + 14'h0001 : mem_addr_q;
  wire mem_we_d = cmd_write || cmd_fill || (state_q == ST_FILL && !fill_done);
  wire mem_re_d = cmd_read;

  // configuration register writes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      vsync_cursor_underline_cfg_q <= REG_RESET;
      buffer_first_address_low_q <= REG_RESET;
      buffer_bounds_high_q <= REG_RESET;
      split_row_one_scroll_start_q <= REG_RESET;
      split_row_two_scroll_end_q <= REG_RESET;
      double_size_and_scroll_lines_q <= REG_RESET;
    end else if (ce && reg_wr) begin
      if (hit(reg_addr, ADDR_VCU_CFG)) vsync_cursor_underline_cfg_q <= reg_wdata;
      if (hit(reg_addr, ADDR_FIRST_LOW)) buffer_first_address_low_q <= reg_wdata;
      if (hit(reg_addr, ADDR_BOUNDS_HIGH)) buffer_bounds_high_q <= reg_wdata;
      if (hit(reg_addr, ADDR_SPLIT_ONE)) split_row_one_scroll_start_q <= reg_wdata;
      if (hit(reg_addr, ADDR_SPLIT_TWO)) split_row_two_scroll_end_q <= reg_wdata;
      if (hit(reg_addr, ADDR_DOUBLE_LINES)) double_size_and_scroll_lines_q <= reg_wdata;
    end
  end

  // pointer, cursor and data registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pointer_address_low_q <= REG_RESET;
      pointer_high_and_scroll_zero_q <= REG_RESET;
      cursor_q <= 14'h0000;
      data_q <= REG_RESET;
    end else if (ce) begin
      if (reg_wr && !ptr_lock && hit(reg_addr, ADDR_PTR_LOW)) pointer_address_low_q <= reg_wdata;
      if (reg_wr && hit(reg_addr, ADDR_PTR_HIGH)) begin
        // zero-line bits stay writable, pointer bits only when ready
        pointer_high_and_scroll_zero_q[7:6] <= reg_wdata[7:6];
        if (!ptr_lock) pointer_high_and_scroll_zero_q[5:0] <= reg_wdata[5:0];
      end
      if (reg_wr && hit(reg_addr, ADDR_CURSOR_LOW)) cursor_q[7:0] <= reg_wdata;
      if (reg_wr && hit(reg_addr, ADDR_CURSOR_HIGH)) cursor_q[13:8] <= reg_wdata[5:0];
      if (state_q == ST_CAPTURE) begin
        data_q <= mem_rdata;
      end else if (reg_wr && hit(reg_addr, ADDR_DATA)) begin
        data_q <= reg_wdata;
      end
    end
  end

  // sequencer and memory port
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      mem_addr_q <= 14'h0000;
      mem_we_q <= 1'b0;
      mem_re_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      mem_addr_q <= mem_addr_d;
      mem_we_q <= mem_we_d;
      mem_re_q <= mem_re_d;
    end
  end

  // display side registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata_q <= 8'h00;
      split_stat_q <= 2'h0;
      blank_q <= 1'b1;
      ul_phase_q <= 1'b0;
      dw_cond_q <= DS_NORMAL;
      ul_pin_q <= 1'b0;
      dw_pin_q <= 1'b0;
      line_address_q <= 4'h0;
      scroll_offset_q <= 4'h0;
    end else if (ce) begin
      reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
      split_stat_q <= split_stat_d;
      blank_q <= blank;
      ul_phase_q <= ul_phase_d;
      dw_cond_q <= dw_cond_d; // held until the next split changes it
      ul_pin_q <= ul_pin_d;
      dw_pin_q <= dw_pin_d;
      line_address_q <= line_address_d;
      scroll_offset_q <= scroll_offset_d;
    end
  end

  // cursor blink divider
  dbsc_blink u_blink (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .vsync_pulse(vsync_pulse),
    .blink_en(vsync_cursor_underline_cfg_q[CFG_BLINK_EN_BIT]),
    .rate_slow(vsync_cursor_underline_cfg_q[CFG_BLINK_RATE_BIT]),
    .blink_q(blink_q)
  );

  // display address with wraparound; split loads may leave the bounds
  dbsc_wrap u_wrap (
    .core_clk(core_clk),
    .reset(reset),
    .ce(ce),
    .frame_start(frame_start),
    .char_adv(char_adv),
    .row_end(row_end),
    .screen_end(screen_end),
    .start_reloaded(start_reloaded),
    .split_load(split_load),
    .screen_start(screen_start),
    .split_addr(split_addr),
    .first_addr(first_addr),
    .last_nib(last_nib),
    .disp_addr_q(disp_addr_q)
  );

  // outputs, all from flops
  assign reg_rdata = reg_rdata_q;
  assign mem_addr = mem_addr_q;
  assign mem_wdata = data_q;
  assign mem_we = mem_we_q;
  assign mem_re = mem_re_q;
  assign disp_addr = disp_addr_q;
  assign address_underline_shared_pin = ul_pin_q;
  assign address_double_width_shared_pin = dw_pin_q;
  assign line_address = line_address_q;
  assign scroll_offset = scroll_offset_q;
  assign row_double = dw_cond_q;
  assign cursor_blink = blink_q;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_write_taken;
    ce && cmd_write;
  endsequence
  sequence s_write_done;
    mem_we_q && mem_addr_q == $past(pointer) ##1 ce [*1] ##0 !mem_we_q;
  endsequence
  property p_write_at_ptr;
    s_write_taken |=> s_write_done;
  endproperty
  a_write_at_ptr: assert property (p_write_at_ptr) else $error("write not at pointer");

  property p_read_at_ptr;
    ce && cmd_read |=> mem_re_q && mem_addr_q == $past(pointer) && !pointer_ready_flag;
  endproperty
  a_read_at_ptr: assert property (p_read_at_ptr) else $error("read not at pointer");

  property p_fill_stop;
    ce && state_q == ST_FILL && mem_we_q && mem_addr_q == pointer |=> !mem_we_q && is_idle;
  endproperty
  a_fill_stop: assert property (p_fill_stop) else $error("fill ran past pointer");

  property p_ptr_locked;
    !is_idle && ce |=> $stable(pointer);
  endproperty
  a_ptr_locked: assert property (p_ptr_locked) else $error("pointer changed while busy");

  property p_zero_lines_scroll_down;
    ce && force_down |=> line_address_q == 4'h0;
  endproperty
  a_zero_lines_scroll_down: assert property (p_zero_lines_scroll_down) else $error("line address not zero on down");

  property p_zero_lines_scroll_up;
    ce && partial_row && !scroll_down && !zero_lines_scroll_up |=> line_address_q == $past(line_count);
  endproperty
  a_zero_lines_scroll_up: assert property (p_zero_lines_scroll_up) else $error("line count not passed on up");

  property p_split_set;
    ce && split1_hit |=> split_stat_q[STAT_SPLIT1_BIT] && status_word[STAT_SPLIT1_BIT];
  endproperty
  a_split_set: assert property (p_split_set) else $error("split status not set");

  property p_scroll_off;
    ce |=> scroll_offset_q == ($past(scroll_on) ? $past(lines_to_scroll_field) : 4'h0);
  endproperty
  a_scroll_off: assert property (p_scroll_off) else $error("scroll offset wrong");

  property p_ul_pin;
    ce && blank_fall |=> address_underline_shared_pin == $past(ul_hit);
  endproperty
  a_ul_pin: assert property (p_ul_pin) else $error("underline not on pin");
endmodule
`default_nettype wire

//--- test/dbsc_mem_model.sv
// behavioural display buffer memory answering the block's pointer accesses
`timescale 1ns/1ps
`default_nettype none
module dbsc_mem_model (
  // clocking
  input wire logic core_clk,
  // buffer port
  input wire logic [13:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem_q [16384]; // whole fourteen bit space
  initial begin
    foreach (mem_q[i]) mem_q[i] = 8'h00;
  end
  // reads answer one cycle later; otherwise toggle so stale data never looks valid
  always @(posedge core_clk) begin
    if (mem_we) begin
      mem_q[mem_addr] <= mem_wdata;
    end
    mem_rdata <= mem_re ? mem_q[mem_addr] : ~mem_rdata;
  end
endmodule
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the display buffer and scroll config block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dbsc_pkg::*;
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin num_errors++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
  logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, blank = 1'b1;
  logic vsync_pulse = 1'b0, frame_start = 1'b0, char_adv = 1'b0, screen_end = 1'b0;
  logic first_line = 1'b0, partial_row = 1'b0, scroll_down = 1'b0, ce = 1'b1;
  logic row_end = 1'b0, start_reloaded = 1'b0, split_load = 1'b0;
  logic [3:0] reg_addr = 4'h0, line_count = 4'h0, line_address, scroll_offset;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rd_q, mem_rdata, mem_wdata;
  logic [6:0] row_index = 7'h00;
  logic [13:0] screen_start = 14'h0000, split_addr = 14'h0000, mem_addr, disp_addr;
  logic mem_we, mem_re, ul_pin, dw_pin, cursor_blink, prev;
  logic [1:0] row_double;
  int num_errors = 0, tests_run = 0, n;
  // 25 MHz core clock
  always #20 core_clk = ~core_clk;
  dbsc_top dbsc_top_inst (.core_clk(core_clk), .reset(reset), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we),
    .mem_re(mem_re), .mem_rdata(mem_rdata), .blank(blank), .vsync_pulse(vsync_pulse),
    .frame_start(frame_start), .char_adv(char_adv), .row_end(row_end),
    .screen_end(screen_end), .start_reloaded(start_reloaded), .first_line(first_line),
    .row_index(row_index), .line_count(line_count), .partial_row(partial_row),
    .scroll_down(scroll_down), .split_load(split_load), .split_addr(split_addr),
    .screen_start(screen_start), .disp_addr(disp_addr),
    .address_underline_shared_pin(ul_pin), .address_double_width_shared_pin(dw_pin),
    .line_address(line_address), .scroll_offset(scroll_offset),
    .row_double(row_double), .cursor_blink(cursor_blink));
  dbsc_mem_model dbsc_mem_model_inst (.core_clk(core_clk), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata));
  // verdict and end of run, also reached when a wait runs out
  task automatic give_verdict;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read strobe, data taken in the following cycle only
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  // let registered outputs settle before sampling
  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // bounded poll of the ready flag
  task automatic wait_ready;
    int i;
    for (i = 0; i < 50; i++) begin
      rd(ADDR_STATUS);
      if (rd_q[STAT_READY_BIT] === 1'b1) break;
    end
    if (i == 50) begin num_errors++; $display("BAD %0t ready timeout", $time); give_verdict(); end
  endtask
  // reset values, readback and an unmapped offset
  task automatic t_regs;
    rd(ADDR_VCU_CFG); `CHK(rd_q, REG_RESET)
    wr(ADDR_PTR_LOW, 8'h34); rd(ADDR_PTR_LOW); `CHK(rd_q, 8'h34)
    cyc(1); `CHK(reg_rdata, 8'h00)
    // a write while the clock enable is low must leave the register alone
    @(posedge core_clk); ce <= 1'b0;
    wr(ADDR_PTR_LOW, 8'h56);
    @(posedge core_clk); ce <= 1'b1;
    rd(ADDR_PTR_LOW); `CHK(rd_q, 8'h34)
    rd(4'h5); `CHK(rd_q, 8'h00)
  endtask
  // write then read back through the pointer commands
  task automatic t_pointer;
    wr(ADDR_PTR_HIGH, 8'h12); wr(ADDR_DATA, 8'h5a); wr(ADDR_COMMAND, CMD_WRITE_PTR);
    wait_ready();
    `CHK(dbsc_mem_model_inst.mem_q[14'h1234], 8'h5a)
    wr(ADDR_DATA, 8'h00); wr(ADDR_COMMAND, CMD_READ_PTR); wait_ready();
    rd(ADDR_DATA); `CHK(rd_q, 8'h5a)
  endtask
  // fill from cursor stops exactly at the pointer
  task automatic t_fill;
    wr(ADDR_CURSOR_LOW, 8'h30); wr(ADDR_CURSOR_HIGH, 8'h12); wr(ADDR_DATA, 8'hc3);
    wr(ADDR_COMMAND, CMD_FILL_TO_PTR);
    wr(ADDR_PTR_LOW, 8'h00);
    wait_ready();
    rd(ADDR_PTR_LOW); `CHK(rd_q, 8'h34)
    for (int a = 14'h1230; a <= 14'h1234; a++) `CHK(dbsc_mem_model_inst.mem_q[a], 8'hc3)
    `CHK(dbsc_mem_model_inst.mem_q[14'h1235], 8'h00)
  endtask
  // zero-line forcing on partial rows in both scroll directions
  task automatic t_zero;
    @(posedge core_clk); partial_row <= 1'b1; line_count <= 4'h5; scroll_down <= 1'b1;
    wr(ADDR_PTR_HIGH, 8'h92); cyc(2); `CHK(line_address, 4'h0)
    wr(ADDR_PTR_HIGH, 8'h12); cyc(2); `CHK(line_address, 4'h5)
    @(posedge core_clk); scroll_down <= 1'b0;
    wr(ADDR_PTR_HIGH, 8'h52); cyc(2); `CHK(line_address, 4'h0)
    wr(ADDR_PTR_HIGH, 8'h12); cyc(2); `CHK(line_address, 4'h5)
    @(posedge core_clk); partial_row <= 1'b0;
  endtask
  // scroll offset gating, split match, double width
  task automatic t_split;
    wr(ADDR_DOUBLE_LINES, 8'h47); wr(ADDR_SPLIT_ONE, 8'h85); cyc(2);
    `CHK(scroll_offset, 4'h0)
    wr(ADDR_SPLIT_TWO, 8'h80); cyc(2); `CHK(scroll_offset, 4'h7)
    for (int r = 4; r <= 5; r++) begin
      @(posedge core_clk); row_index <= 7'(r); first_line <= 1'b1;
      @(posedge core_clk); first_line <= 1'b0;
      rd(ADDR_STATUS); `CHK(rd_q[STAT_SPLIT1_BIT], 1'(r == 5))
    end
    wr(ADDR_STATUS, 8'h01); rd(ADDR_STATUS); `CHK(rd_q[STAT_SPLIT1_BIT], 1'b0)
    cyc(1); `CHK(row_double, DS_WIDE)
  endtask
  // underline timing on the shared pin after blank falls
  task automatic t_underline;
    wr(ADDR_VCU_CFG, 8'h03);
    @(posedge core_clk); screen_start <= 14'h0000; frame_start <= 1'b1;
    @(posedge core_clk); frame_start <= 1'b0; line_count <= 4'h3;
    cyc(2); `CHK(ul_pin, 1'b0)
    @(posedge core_clk); blank <= 1'b0;
    cyc(2); `CHK(ul_pin, 1'b1)
    `CHK(dw_pin, 1'b1)
    @(posedge core_clk); line_count <= 4'h4;
    cyc(2); `CHK(ul_pin, 1'b0)
    @(posedge core_clk); blank <= 1'b1;
  endtask
  // past the last address: plain wrap, screen end, reloaded row end; then a split load
  task automatic t_wrap;
    wr(ADDR_FIRST_LOW, 8'h10); wr(ADDR_BOUNDS_HIGH, 8'h00);
    for (int s = 0; s <= 2; s++) begin
      @(posedge core_clk); screen_start <= 14'h03fe; frame_start <= 1'b1;
      screen_end <= 1'(s == 1); row_end <= 1'(s == 2); start_reloaded <= 1'(s == 2);
      @(posedge core_clk); frame_start <= 1'b0; char_adv <= 1'b1;
      @(posedge core_clk);
      @(posedge core_clk); char_adv <= 1'b0;
      cyc(1); `CHK(disp_addr, (s == 0) ? 14'h0010 : 14'h03fe)
    end
    @(posedge core_clk); screen_end <= 1'b0; row_end <= 1'b0; start_reloaded <= 1'b0;
    split_addr <= 14'h3800; split_load <= 1'b1;
    @(posedge core_clk); split_load <= 1'b0;
    cyc(1); `CHK(disp_addr, 14'h3800)
  endtask
  // count blink changes over 64 frames for fast, slow and disabled
  task automatic t_blink;
    logic [7:0] cfg [3] = '{8'h20, 8'h30, 8'h00};
    int exp [3] = '{4, 2, 0};
    for (int k = 0; k < 3; k++) begin
      wr(ADDR_VCU_CFG, cfg[k]); cyc(2); prev = cursor_blink; n = 0;
      repeat (64) begin
        @(posedge core_clk); vsync_pulse <= 1'b1;
        @(posedge core_clk); vsync_pulse <= 1'b0;
        cyc(1);
        if (cursor_blink !== prev) n++;
        prev = cursor_blink;
      end
      `CHK(n, exp[k])
    end
    `CHK(cursor_blink, 1'b1)
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    t_regs(); t_pointer(); t_fill(); t_zero(); t_split(); t_underline(); t_wrap(); t_blink();
    give_verdict();
  end
endmodule
`default_nettype wire
